/* File: vc_arb_pkg.sv */
// Package with offsets, field layouts and reset values of the VC arbitration block.
package vc_arb_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses in configuration space)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CAP_ONE = 12'h14c;
    localparam logic [11:0] OFF_CAP_TWO = 12'h150;
    localparam logic [11:0] OFF_VC_CTRL = 12'h154;
    localparam logic [11:0] OFF_CH0_CAP = 12'h158;
    localparam logic [11:0] OFF_CH0_CTRL = 12'h15c;
    localparam logic [11:0] OFF_CH0_STAT = 12'h160;
    localparam logic [11:0] OFF_CH1_CAP = 12'h164;
    localparam logic [11:0] OFF_CH1_CTRL = 12'h168;
    localparam logic [11:0] OFF_CH1_STAT = 12'h16c;
    localparam logic [11:0] OFF_VC_TABLE = 12'h188;
    localparam logic [11:0] OFF_PORT_TABLE0 = 12'h198;
    localparam logic [11:0] OFF_PORT_TABLE1 = 12'h1a8;
    localparam logic [11:0] OFF_IRQ_ROUTE = 12'h1c8;
    localparam int TABLE_WORDS = 4;
    localparam int TABLE_WORD_BITS = 2;

    // ------------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------------
    localparam logic [1:0] REF_CLK_100NS = 2'h0;
    localparam logic [1:0] PORT_ENTRY_4BIT = 2'h2;
    localparam logic [7:0] VC_ARB_CAP = 8'h00;
    localparam logic [7:0] VC_TABLE_OFS_CH1 = 8'h04;
    localparam logic [7:0] PORT_CAP_CH0 = 8'h03;
    localparam logic [7:0] PORT_CAP_CH1 = 8'h13;
    localparam logic [6:0] MAX_SLOTS = 7'h3f;
    localparam logic [7:0] PORT_TABLE_OFS_CH0 = 8'h05;
    localparam logic [7:0] PORT_TABLE_OFS_CH1 = 8'h06;
    localparam logic [7:0] TC_MAP_CH0_RESET = 8'hff;
    localparam logic [2:0] CH1_ID_RESET = 3'h1;
    localparam logic [2:0] EXT_COUNT_RESET = 3'h0;
    localparam logic [2:0] VC_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] VC_SEL_WRR = 3'h1;
    localparam logic [2:0] PORT_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] PORT_SEL_WRR = 3'h3;
    localparam logic [2:0] PORT_SEL_TWRR = 3'h4;
    localparam int LOAD_CYCLES = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  byteEn;
    } cfg_req_t;

    typedef struct packed {
        logic [7:0] tcMap;
        logic [2:0] portSel;
        logic [2:0] channelId;
        logic       enable;
    } chan_ctrl_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_BUSY = 2'b01
    } load_state_t;
endpackage

/* File: table_loader.sv */
// Table load sequencer: status flag and commit pulse for one arbitration table.
`timescale 1ns/1ps
module table_loader #(
    parameter int LOAD_LEN = vc_arb_pkg::LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tableWrite,
    input wire logic loadCmd,
    output logic dirty,
    output logic commit
);
    import vc_arb_pkg::*;

    load_state_t state_reg, state_next;
    logic [7:0] count_reg, count_next;
    logic dirty_reg, dirty_next;
    wire logic done = (state_reg == LD_BUSY) &&
        (count_reg == 8'(LOAD_LEN - 1));

    // The load takes a few cycles; a write in the commit cycle keeps the
    // flag set, since the arbiter may have copied the old entry.
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            LD_IDLE: begin
                count_next = 8'h00;
                if (loadCmd) begin
                    state_next = LD_BUSY;
                end
            end
            LD_BUSY: begin
                count_next = count_reg + 8'h01;
                if (done) begin
                    state_next = LD_IDLE;
                end
            end
        endcase
        dirty_next = tableWrite ? 1'b1 : (done ? 1'b0 : dirty_reg);
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= LD_IDLE;
            count_reg <= 8'h00;
            dirty_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            dirty_reg <= dirty_next;
        end
    end

    assign dirty = dirty_reg;
    assign commit = done;
endmodule // table_loader

/* File: vc_port_arbitration_config.sv */
// Virtual channel and port arbitration configuration register bank.
// Notes on behaviour
// - Reference clock field reads 00b.
// - Port table entry size reads 10b.
// - VC arbitration capability reads 00h.
// - VC table offset 04h if channel present.
// - Writing one to bit 0 loads VC table.
// - VC select keeps 0/1, else default.
// - VC table status sets on write, clears after load.
// - Port capability 03h, second 13h or 00h.
// - Time-based scheme accepted only on second channel.
// - Max time slots 3Fh; second 00h if absent.
// - Traffic class map, bit 0 fixed per channel.
// - Bit 16 loads port table, reads zero.
// - Port select keeps legal values, else default.
// - Channel ID fixed 000b, second writable 001b.
// - Enable bit resets 1 then 0.
// - Port table status sets on write, clears after load.
// - Negotiation pending follows the link negotiation.
// - VC table 32 four-bit phases, reset zero.
// - Port tables 32 phases, four words each.
// - Port table offsets 05h and 06h or 00h.
// - Bit 4 routes events to pin or message.
// - Snoop rejection bit reads zero.
// - Extended channel counts read 000b.
`timescale 1ns/1ps
module vc_port_arbitration_config #(
    parameter bit SECOND_CHANNEL_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire vc_arb_pkg::cfg_req_t cfgReq,
    output logic [31:0] cfgRdata,
    output logic cfgAck,
    input wire logic [1:0] negotiationPending,
    input wire logic eventIrq,
    output logic eventMsgReq,
    output logic legacy_irq_pin_n,
    output logic vcTableCommit,
    output logic [1:0] portTableCommit,
    output logic [2:0] vcArbSelect,
    output vc_arb_pkg::chan_ctrl_t [1:0] channelCtrl,
    output logic [127:0] vcTableFlat,
    output logic [255:0] portTableFlat
);
    import vc_arb_pkg::*;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic [1:0] negSync1_reg, negSync2_reg, irqSync1_reg, irqSync2_reg;
    wire logic wr = cfgReq.valid && cfgReq.write;
    wire logic [11:0] a = cfgReq.addr;
    wire logic [31:0] mask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}},
        {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
    wire logic [31:0] wd = cfgReq.wdata & mask;
    wire logic wrVcCtrl = wr && (a == OFF_VC_CTRL);
    wire logic wrCh0 = wr && (a == OFF_CH0_CTRL);
    wire logic wrCh1 = wr && (a == OFF_CH1_CTRL);
    wire logic wrRoute = wr && (a == OFF_IRQ_ROUTE) && cfgReq.byteEn[0];
    wire logic [11:0] vcRel = a - OFF_VC_TABLE;
    wire logic [11:0] p0Rel = a - OFF_PORT_TABLE0;
    wire logic [11:0] p1Rel = a - OFF_PORT_TABLE1;
    wire logic inVc = (a >= OFF_VC_TABLE) && (vcRel < 12'h010);
    wire logic inP0 = (a >= OFF_PORT_TABLE0) && (p0Rel < 12'h010);
    wire logic inP1 = (a >= OFF_PORT_TABLE1) && (p1Rel < 12'h010);

    // ------------------------------------------------------------------
    // Arbitration tables
    // ------------------------------------------------------------------
    logic [31:0] vcTable_reg [TABLE_WORDS];
    logic [31:0] portTable_reg [2][TABLE_WORDS];
    logic [1:0] portWrite;

    // One word per loop entry; byte enables merge into the old word.
    genvar gi;
    generate
        for (gi = 0; gi < TABLE_WORDS; gi++) begin : g_tab
            wire logic [1:0] idx = 2'(gi);
            wire logic hitV = wr && inVc &&
                (vcRel[3:2] == idx);
            wire logic hitP0 = wr && inP0 && (p0Rel[3:2] == idx);
            wire logic hitP1 = wr && inP1 && (p1Rel[3:2] == idx);
            // The reserved top bit of each VC phase stays zero.
            always_ff @(posedge clk) begin
                if (reset) begin
                    vcTable_reg[gi] <= 32'h0000_0000;
                    portTable_reg[0][gi] <= 32'h0000_0000;
                    portTable_reg[1][gi] <= 32'h0000_0000;
                end else begin
                    if (hitV) begin
                        vcTable_reg[gi] <= ((vcTable_reg[gi] & ~mask) | wd)
                            & 32'h7777_7777;
                    end
                    if (hitP0) begin
                        portTable_reg[0][gi] <= (portTable_reg[0][gi] &
                            ~mask) | wd;
                    end
                    if (hitP1) begin
                        portTable_reg[1][gi] <= (portTable_reg[1][gi] &
                            ~mask) | wd;
                    end
                end
            end
            assign vcTableFlat[gi*32 +: 32] = vcTable_reg[gi];
            assign portTableFlat[gi*32 +: 32] = portTable_reg[0][gi];
            assign portTableFlat[128 + gi*32 +: 32] = portTable_reg[1][gi];
        end
    endgenerate

    assign portWrite = {wr && inP1, wr && inP0};

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [2:0] vcSel_reg;
    chan_ctrl_t ch0_reg, ch1_reg;
    logic routePin_reg;
    wire logic [2:0] vcSelIn = wd[3:1];
    wire logic [2:0] p0SelIn = wd[19:17];
    wire logic [2:0] p1SelIn = wd[19:17];
    wire logic vcSelOk = (vcSelIn == VC_SEL_DEFAULT) ||
        (vcSelIn == VC_SEL_WRR);
    wire logic p0SelOk = (p0SelIn == PORT_SEL_DEFAULT) ||
        (p0SelIn == PORT_SEL_WRR);
    wire logic p1SelOk = (p1SelIn == PORT_SEL_DEFAULT) ||
        (p1SelIn == PORT_SEL_WRR) ||
        (SECOND_CHANNEL_PRESENT && p1SelIn == PORT_SEL_TWRR);
    wire logic [2:0] vcSelNext = vcSelOk ? vcSelIn : VC_SEL_DEFAULT;
    wire logic [2:0] p0SelNext = p0SelOk ? p0SelIn : PORT_SEL_DEFAULT;
    wire logic [2:0] p1SelNext = p1SelOk ? p1SelIn : PORT_SEL_DEFAULT;
    wire logic [2:0] ch1IdReset = SECOND_CHANNEL_PRESENT ? CH1_ID_RESET :
        3'h0;

    // Illegal scheme codes fall back to the default scheme rather than
    // keeping the old one, so software always reads what hardware runs.
    always_ff @(posedge clk) begin
        if (reset) begin
            vcSel_reg <= VC_SEL_DEFAULT;
            ch0_reg <= '{tcMap: TC_MAP_CH0_RESET, portSel: PORT_SEL_DEFAULT,
                channelId: 3'h0, enable: 1'b1};
            ch1_reg <= '{tcMap: 8'h00, portSel: PORT_SEL_DEFAULT,
                channelId: ch1IdReset, enable: 1'b0};
            routePin_reg <= 1'b0;
        end else begin
            if (wrVcCtrl && cfgReq.byteEn[0]) begin
                vcSel_reg <= vcSelNext;
            end
            if (wrCh0 && cfgReq.byteEn[0]) begin
                ch0_reg.tcMap <= {wd[7:1], 1'b1};
            end
            if (wrCh0 && cfgReq.byteEn[2]) begin
                ch0_reg.portSel <= p0SelNext;
            end
            if (wrCh0 && cfgReq.byteEn[3]) begin
                ch0_reg.enable <= wd[31];
            end
            if (wrCh1 && cfgReq.byteEn[0]) begin
                ch1_reg.tcMap <= {wd[7:1], 1'b0};
            end
            if (wrCh1 && cfgReq.byteEn[2]) begin
                ch1_reg.portSel <= p1SelNext;
            end
            if (wrCh1 && cfgReq.byteEn[3]) begin
                ch1_reg.channelId <= wd[26:24];
                ch1_reg.enable <= wd[31];
            end
            if (wrRoute) begin
                routePin_reg <= wd[4];
            end
        end
    end

    // The second channel's ID resets to a strap-dependent value, so it
    // reads correctly from the first edge after reset release.
    logic [2:0] ch1Id;
    assign ch1Id = ch1_reg.channelId;

    // ------------------------------------------------------------------
    // Load sequencers
    // ------------------------------------------------------------------
    logic vcDirty;
    logic [1:0] portDirty;

    table_loader #(.LOAD_LEN(LOAD_CYCLES)) u_vc_loader (
        .clk(clk),
        .reset(reset),
        .tableWrite(wr && inVc),
        .loadCmd(wrVcCtrl && cfgReq.byteEn[0] && wd[0]),
        .dirty(vcDirty),
        .commit(vcTableCommit)
    );

    generate
        for (gi = 0; gi < 2; gi++) begin : g_port_ld
            wire logic ld = (gi == 0 ? wrCh0 : wrCh1) &&
                cfgReq.byteEn[2] && wd[16];
            table_loader #(.LOAD_LEN(LOAD_CYCLES)) u_port_loader (
                .clk(clk),
                .reset(reset),
                .tableWrite(portWrite[gi]),
                .loadCmd(ld),
                .dirty(portDirty[gi]),
                .commit(portTableCommit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin synchronisers and interrupt routing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            negSync1_reg <= 2'h0;
            negSync2_reg <= 2'h0;
            irqSync1_reg <= 2'h0;
            irqSync2_reg <= 2'h0;
        end else begin
            negSync1_reg <= negotiationPending;
            negSync2_reg <= negSync1_reg;
            irqSync1_reg <= {1'b0, eventIrq};
            irqSync2_reg <= irqSync1_reg;
        end
    end

    // The pin is a level while the event lasts; the message request is
    // a level too, so the message engine decides assert and deassert.
    logic pinN_reg, msg_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            pinN_reg <= 1'b1;
            msg_reg <= 1'b0;
        end else begin
            pinN_reg <= ~(irqSync2_reg[0] && routePin_reg);
            msg_reg <= irqSync2_reg[0] && !routePin_reg;
        end
    end
    assign legacy_irq_pin_n = pinN_reg;
    assign eventMsgReq = msg_reg;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire logic [31:0] capOne = {20'h0, PORT_ENTRY_4BIT, REF_CLK_100NS,
        1'b0, EXT_COUNT_RESET, 1'b0, EXT_COUNT_RESET};
    // (both channel counts report no extra channels).
    wire logic [31:0] capTwo = {SECOND_CHANNEL_PRESENT ? VC_TABLE_OFS_CH1 :
        8'h00, 16'h0, VC_ARB_CAP};
    wire logic [31:0] vcCtrlRd = {15'h0, vcDirty, 12'h0, vcSel_reg,
        1'b0};
    wire logic [31:0] ch0Cap = {PORT_TABLE_OFS_CH0, 1'b0, MAX_SLOTS,
        1'b0, 1'b0, 6'h0, PORT_CAP_CH0};
    wire logic [31:0] ch1Cap = SECOND_CHANNEL_PRESENT ?
        {PORT_TABLE_OFS_CH1, 1'b0, MAX_SLOTS, 1'b0, 1'b0, 6'h0,
        PORT_CAP_CH1} : 32'h0000_0000;
    wire logic [31:0] ch0CtrlRd = {ch0_reg.enable, 4'h0, 3'h0, 4'h0,
        ch0_reg.portSel, 1'b0, 8'h00, ch0_reg.tcMap};
    wire logic [31:0] ch1CtrlRd = {ch1_reg.enable, 4'h0, ch1Id, 4'h0,
        ch1_reg.portSel, 1'b0, 8'h00, ch1_reg.tcMap};
    wire logic [31:0] ch0Stat = {14'h0, negSync2_reg[0], portDirty[0],
        16'h0};
    wire logic [31:0] ch1Stat = {14'h0, negSync2_reg[1], portDirty[1],
        16'h0};
    wire logic [31:0] routeRd = {27'h0, routePin_reg, 4'h0};

    // Unlisted addresses and reserved fields read zero.
    logic [31:0] rdNext;
    always_comb begin
        rdNext = 32'h0000_0000;
        if (inVc) begin
            rdNext = vcTable_reg[vcRel[3:2]];
        end else if (inP0) begin
            rdNext = portTable_reg[0][p0Rel[3:2]];
        end else if (inP1) begin
            rdNext = portTable_reg[1][p1Rel[3:2]];
        end else begin
            unique case (a)
                OFF_CAP_ONE: rdNext = capOne;
                OFF_CAP_TWO: rdNext = capTwo;
                OFF_VC_CTRL: rdNext = vcCtrlRd;
                OFF_CH0_CAP: rdNext = ch0Cap;
                OFF_CH0_CTRL: rdNext = ch0CtrlRd;
                OFF_CH0_STAT: rdNext = ch0Stat;
                OFF_CH1_CAP: rdNext = ch1Cap;
                OFF_CH1_CTRL: rdNext = ch1CtrlRd;
                OFF_CH1_STAT: rdNext = ch1Stat;
                OFF_IRQ_ROUTE: rdNext = routeRd;
                default: rdNext = 32'h0000_0000;
            endcase
        end
    end

    // Every access is answered one cycle later.
    logic [31:0] rd_reg;
    logic ack_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
        end else begin
            rd_reg <= (cfgReq.valid && !cfgReq.write) ? rdNext : 32'h0;
            ack_reg <= cfgReq.valid;
        end
    end

    assign cfgRdata = rd_reg;
    assign cfgAck = ack_reg;
    assign vcArbSelect = vcSel_reg;
    assign channelCtrl[0] = ch0_reg;
    assign channelCtrl[1] = '{tcMap: ch1_reg.tcMap,
        portSel: ch1_reg.portSel, channelId: ch1Id,
        enable: ch1_reg.enable};
endmodule // vc_port_arbitration_config

/* File: cfg_host.sv */
// Host model issuing configuration accesses to the bank.
`timescale 1ns/1ps
module cfg_host (
    input wire logic clk,
    output vc_arb_pkg::cfg_req_t cfgReq,
    input wire logic [31:0] cfgRdata,
    input wire logic cfgAck
);
    import vc_arb_pkg::*;
    // -----------------------------------------------------------------
    // Access sequencing
    // -----------------------------------------------------------------
    // Idle from time zero.
    initial begin
        cfgReq = '0;
    end
    // One request cycle; released lines invert to catch late sampling.
    task automatic access(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        cfgReq <= '{valid: 1'b1, write: wr, addr: a, wdata: d, byteEn: 4'hf};
        @(negedge clk);
        cfgReq <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d,
            byteEn: 4'h0};
        q = (cfgAck === 1'b1) ? cfgRdata : 32'hxxxx_xxxx;
    endtask
endmodule // cfg_host

/* File: vc_arb_properties.sv */
// Port-level checker of the arbitration register bank.
`timescale 1ns/1ps
module vc_arb_properties (
    input wire logic clk,
    input wire logic reset,
    input wire vc_arb_pkg::cfg_req_t cfgReq,
    input wire logic [31:0] cfgRdata,
    input wire logic eventIrq,
    input wire logic eventMsgReq,
    input wire logic legacy_irq_pin_n,
    input wire logic vcTableCommit,
    input wire logic [1:0] portTableCommit,
    input wire logic [2:0] vcArbSelect,
    input wire vc_arb_pkg::chan_ctrl_t [1:0] channelCtrl
);
    import vc_arb_pkg::*;
    // -----------------------------------------------------------------
    // Request decode and expected select codes
    // -----------------------------------------------------------------
    // Loads need their byte lane, as in the bank.
    wire rdReq = cfgReq.valid && !cfgReq.write;
    wire wrReq = cfgReq.valid && cfgReq.write;
    wire wrVc = wrReq && cfgReq.addr == OFF_VC_CTRL && cfgReq.byteEn[0];
    wire wrCh0 = wrReq && cfgReq.addr == OFF_CH0_CTRL && cfgReq.byteEn[2];
    wire wrCh1 = wrReq && cfgReq.addr == OFF_CH1_CTRL && cfgReq.byteEn[2];
    wire [2:0] vcSel = cfgReq.wdata[3:1];
    wire [2:0] pSel = cfgReq.wdata[19:17];
    wire [2:0] vcOk = (vcSel <= VC_SEL_WRR) ? vcSel : VC_SEL_DEFAULT;
    wire [2:0] sel0Ok = (pSel == PORT_SEL_WRR) ? pSel : PORT_SEL_DEFAULT;
    wire sel1Legal = pSel == PORT_SEL_WRR || pSel == PORT_SEL_TWRR;
    wire [2:0] sel1Ok = sel1Legal ? pSel : PORT_SEL_DEFAULT;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Register answers and load timing.
    a_cap_word: assert property (rdReq && cfgReq.addr == OFF_CAP_ONE
        |=> cfgRdata == 32'h0000_0800) else $error("capability word wrong");
    a_ctrl_readback: assert property (rdReq && cfgReq.addr == OFF_VC_CTRL
        |=> !cfgRdata[0] && cfgRdata[15:4] == 12'h0 && cfgRdata[31:17] == 15'h0)
        else $error("control word bits");
    a_vc_load_done: assert property (wrVc && cfgReq.wdata[0]
        |-> ##4 vcTableCommit) else $error("vc table commit late");
    a_port_load_done: assert property (wrCh1 && cfgReq.wdata[16]
        |-> ##4 portTableCommit[1]) else $error("port table commit late");
    a_vc_select: assert property (wrVc |=> vcArbSelect == $past(vcOk))
        else $error("vc select code wrong");
    a_sel_first: assert property (wrCh0
        |=> channelCtrl[0].portSel == $past(sel0Ok)) else $error("sel0 wrong");
    a_sel_second: assert property (wrCh1
        |=> channelCtrl[1].portSel == $past(sel1Ok)) else $error("sel1 wrong");
    a_fixed_fields: assert property (channelCtrl[0].tcMap[0]
        && channelCtrl[0].channelId == 3'h0 && !channelCtrl[1].tcMap[0])
        else $error("fixed fields");
    a_pin_cause: assert property ($fell(legacy_irq_pin_n)
        |-> $past(eventIrq, 2)) else $error("pin without event");
    // Main scenarios seen.
    c_vc_load: cover property (vcTableCommit);
    c_port_load: cover property (portTableCommit[1]);
    c_pin: cover property (!legacy_irq_pin_n);
    c_msg: cover property (eventMsgReq);
endmodule // vc_arb_properties

bind vc_port_arbitration_config vc_arb_properties i_vc_arb_properties (
    .clk(clk), .reset(reset), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
    .eventIrq(eventIrq), .eventMsgReq(eventMsgReq),
    .legacy_irq_pin_n(legacy_irq_pin_n), .vcTableCommit(vcTableCommit),
    .portTableCommit(portTableCommit), .vcArbSelect(vcArbSelect),
    .channelCtrl(channelCtrl));

/* File: vc_port_arbitration_config_test.sv */
// Self-checking testbench of the arbitration register bank.
`timescale 1ns/1ps
module vc_port_arbitration_config_test;
    import vc_arb_pkg::*;
    logic clk, reset, cfgAck, eventIrq, eventMsgReq, legacy_irq_pin_n;
    logic vcTableCommit;
    logic [1:0] negotiationPending, portTableCommit;
    logic [2:0] vcArbSelect;
    logic [31:0] cfgRdata;
    logic [127:0] vcTableFlat;
    logic [255:0] portTableFlat;
    cfg_req_t cfgReq;
    chan_ctrl_t [1:0] channelCtrl;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    // -----------------------------------------------------------------
    // Harness
    // -----------------------------------------------------------------
    vc_port_arbitration_config i_vc_port_arbitration_config (
        .clk(clk), .reset(reset), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
        .cfgAck(cfgAck), .negotiationPending(negotiationPending),
        .eventIrq(eventIrq), .eventMsgReq(eventMsgReq),
        .legacy_irq_pin_n(legacy_irq_pin_n), .vcTableCommit(vcTableCommit),
        .portTableCommit(portTableCommit), .vcArbSelect(vcArbSelect),
        .channelCtrl(channelCtrl), .vcTableFlat(vcTableFlat),
        .portTableFlat(portTableFlat));
    cfg_host i_cfg_host (.clk(clk), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
        .cfgAck(cfgAck));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, far above the run's length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_cfg_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        i_cfg_host.access(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // Falling edges until a commit pulse, bounded.
    task automatic wait_commit(input int ch, output int n);
        n = 0;
        while ((ch < 0 ? vcTableCommit : portTableCommit[1]) !== 1'b1
            && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset values, fixed fields, tables, route word and a hole.
    task automatic t_reset_values();
        logic [11:0] a [14] = '{OFF_CAP_ONE, OFF_CAP_TWO, OFF_CH0_CAP,
            OFF_CH1_CAP, OFF_VC_CTRL, OFF_CH0_CTRL, OFF_CH0_STAT,
            OFF_CH1_CTRL, OFF_CH1_STAT, OFF_VC_TABLE + 12'hc,
            OFF_PORT_TABLE0 + 12'h4, OFF_PORT_TABLE1, OFF_IRQ_ROUTE, 12'h1d0};
        logic [31:0] e [14] = '{32'h0000_0800, 32'h0400_0000, 32'h053f_0003,
            32'h063f_0013, 32'h0, 32'h8000_00ff, 32'h0, 32'h0100_0000,
            32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 4; i++) begin
            rd(a[i], e[i]);
        end
        rd(OFF_CH1_CAP, 32'h063f_0013);
        for (int i = 4; i < 9; i++) begin
            rd(a[i], e[i]);
        end
        for (int i = 9; i < 14; i++) begin
            rd(a[i], e[i]);
        end
        $display("test reset values done");
    endtask
    // Table write marks status; load commits.
    task automatic t_vc_load();
        int n;
        wr(OFF_VC_TABLE + 12'h4, 32'hffff_ffff);
        rd(OFF_VC_TABLE + 12'h4, 32'h7777_7777);
        rd(OFF_VC_CTRL, 32'h0001_0000);
        wr(OFF_VC_CTRL, 32'h0000_0001);
        wait_commit(-1, n);
        check(n, LOAD_CYCLES - 1);
        check(vcTableFlat[63:32], 32'h7777_7777);
        rd(OFF_VC_CTRL, 32'h0);
        $display("test vc table load done");
    endtask
    // All select codes, reserved bits written high except VC control bits 19:17.
    task automatic t_select_codes();
        logic [2:0] v0, s0, s1;
        for (int v = 0; v < 8; v++) begin
            v0 = (v <= 1) ? 3'(v) : 3'h0;
            s0 = (v == 3) ? 3'(v) : 3'h0;
            s1 = (v == 3 || v == 4) ? 3'(v) : 3'h0;
            wr(OFF_VC_CTRL, 32'hfff0_fff0 | (v << 1));
            rd(OFF_VC_CTRL, {28'h0, v0, 1'b0});
            check({29'h0, vcArbSelect}, {29'h0, v0});
            wr(OFF_CH0_CTRL, 32'hfff0_ff5a | (v << 17));
            wr(OFF_CH1_CTRL, 32'hfff0_ffa5 | (v << 17));
            rd(OFF_CH0_CTRL, 32'h8000_005b | {12'h0, s0, 17'h0});
            rd(OFF_CH1_CTRL, 32'h8700_00a4 | {12'h0, s1, 17'h0});
        end
        $display("test select codes done");
    endtask
    // Second channel port table load, then negotiation.
    task automatic t_port_load();
        int n;
        wr(OFF_PORT_TABLE1 + 12'h8, 32'ha5a5_a5a5);
        rd(OFF_PORT_TABLE1 + 12'h8, 32'ha5a5_a5a5);
        rd(OFF_CH1_STAT, 32'h0001_0000);
        rd(OFF_CH0_STAT, 32'h0);
        wr(OFF_CH1_CTRL, 32'h0001_0000);
        wait_commit(1, n);
        check(n, LOAD_CYCLES - 1);
        check(portTableFlat[223:192], 32'ha5a5_a5a5);
        rd(OFF_CH1_CTRL, 32'h0);
        rd(OFF_CH1_STAT, 32'h0);
        negotiationPending = 2'b10;
        repeat (4) @(negedge clk);
        rd(OFF_CH1_STAT, 32'h0002_0000);
        rd(OFF_CH0_STAT, 32'h0);
        negotiationPending = 2'b00;
        repeat (4) @(negedge clk);
        rd(OFF_CH1_STAT, 32'h0);
        $display("test port table load done");
    endtask
    // Events go to the message, then to the pin.
    task automatic t_event_route();
        eventIrq = 1'b1;
        repeat (5) @(negedge clk);
        check({30'h0, eventMsgReq, legacy_irq_pin_n}, 32'h3);
        eventIrq = 1'b0;
        wr(OFF_IRQ_ROUTE, 32'h0000_001f);
        rd(OFF_IRQ_ROUTE, 32'h0000_0010);
        check({30'h0, eventMsgReq, legacy_irq_pin_n}, 32'h1);
        eventIrq = 1'b1;
        repeat (5) @(negedge clk);
        check({30'h0, eventMsgReq, legacy_irq_pin_n}, 32'h0);
        eventIrq = 1'b0;
        repeat (5) @(negedge clk);
        check({30'h0, eventMsgReq, legacy_irq_pin_n}, 32'h1);
        $display("test event route done");
    endtask
    initial begin
        reset = 1'b1;
        eventIrq = 1'b0;
        negotiationPending = 2'b00;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_reset_values();
        t_vc_load();
        t_select_codes();
        t_port_load();
        t_event_route();
        tally_and_finish();
    end
endmodule // vc_port_arbitration_config_test
